// ===== pkg/daqis_pkg.sv
// Shared constants for the acquisition interrupt source selector.
// Assumes a 40 MHz system clock and an AXI4-Lite register master.
`default_nettype none

package daqis_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and responses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BLKS = 8'h04;
  localparam logic [7:0] OFF_CLR = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_CNT = 8'h14;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_W = 6;
  localparam int CB_ANALOG_IRQ = 0;
  localparam int CB_FIFO_IRQ = 1;
  localparam int CB_DMA = 2;
  localparam int CB_FIFO_MODE = 3;
  localparam int CB_ROUTE = 4;
  localparam int CB_GATE = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [7:0] BLKS_RST = 8'h01;

  // ----------------------------------------------------------------
  // Status and mask fields
  // ----------------------------------------------------------------
  localparam int ST_W = 4;
  localparam int ST_IRQ = 0;
  localparam int ST_EVT = 1;
  localparam int ST_FBLK = 2;
  localparam int ST_GATE = 3;
  localparam logic [ST_W-1:0] MASK_RST = 4'h1;

  // ----------------------------------------------------------------
  // Counting and timing
  // ----------------------------------------------------------------
  localparam logic [8:0] SMP_LAST = 9'h1FF;
  localparam logic [8:0] SMP_STEP = 9'h001;
  localparam logic [7:0] BLK_STEP = 8'h01;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DGL_TIME_NS = 100;
  localparam int DGL_CYCLES = (DGL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] DGL_LAST = 3'(DGL_CYCLES - 1);
  localparam logic [2:0] DGL_STEP = 3'h1;

  // Which event feeds the interrupt request.
  typedef enum logic [2:0] {
    SRC_NONE  = 3'b000,
    SRC_CONV  = 3'b001,
    SRC_BURST = 3'b010,
    SRC_TC    = 3'b011,
    SRC_BLOCK = 3'b100
  } daqis_src_t;

endpackage

`default_nettype wire

// ===== pkg/daqis_dgl_if.sv
// Interface between the selector and its input deglitch filter.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none

interface daqis_dgl_if;
  logic raw; // Unfiltered digital input zero.
  logic level; // Filtered level.
  logic rise; // One-cycle pulse on a filtered rising edge.
  modport filt (input raw, output level, output rise);
  modport user (output raw, input level, input rise);
endinterface

`default_nettype wire

// ===== design/daqis_deglitch.sv
// Deglitch filter for digital input zero.
// Assumes the raw input is already synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none

module daqis_deglitch (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filter channel.
  daqis_dgl_if.filt dg
);
  import daqis_pkg::*;

  logic [2:0] cnt; // Cycles the raw input has differed from the level.
  logic level; // Accepted level.
  logic rise; // Rising edge pulse.
  logic differ; // Raw input disagrees with accepted level.

  assign differ = dg.raw != level;
  assign dg.level = level;
  assign dg.rise = rise;

  // ----------------------------------------------------------------
  // Stability counter
  // ----------------------------------------------------------------
  // A new level is accepted only after it has held for the full window.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 3'h0;
      level <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      rise <= differ && cnt == DGL_LAST && dg.raw;
      if (differ && cnt == DGL_LAST)
      begin
        level <= dg.raw;
        cnt <= 3'h0;
      end
      else
      begin
        cnt <= differ ? cnt + DGL_STEP : 3'h0;
      end
    end
  end

  // A rising pulse always coincides with a high accepted level.
  a_rise_level: assert property (@(posedge clk) disable iff (rst) rise |-> level)
    else $error("Deglitch rise without high level.");

endmodule // daqis_deglitch

`default_nettype wire

// ===== design/daqis_top.sv
// Acquisition interrupt source selector with an AXI4-Lite register slave.
// Assumes event inputs are one-cycle pulses synchronous to CLK.
//
// Behaviour
// - Classic selection only while route bit zero.
// - DMA, no analog enable: poll flag on TC.
// - Analog enable, no DMA: IRQ per conversion.
// - Legacy strap, mode zero: IRQ per sample.
// - Analog enable with DMA: IRQ on TC.
// - FIFO mode, nothing enabled: flag per conversion.
// - FIFO mode with DMA but no analog enable, or with neither FIFO IRQ nor DMA: block flag.
// - FIFO IRQ only: IRQ per sample block.
// - Software programs blocks per FIFO event.
// - FIFO IRQ only: flag on input rise.
// - Clear write also clears edge flag.
// - Legacy burst mode: IRQ per burst.
// - Both enables: IRQ per sample block.
// - Both enables: IRQ on input rise.
// - Input rise marks pacer gating start.
`timescale 1ns/10ps
`default_nettype none

module daqis_top (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // AXI4-Lite write address and data.
  input wire logic [daqis_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response.
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read.
  input wire logic [daqis_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Acquisition events.
  input wire logic CONV_DONE,
  input wire logic BURST_DONE,
  input wire logic BURST_ACTIVE,
  input wire logic DMA_TC,
  input wire logic SAMPLE_QUEUED,
  input wire logic DIGITAL_INPUT_ZERO,
  input wire logic LEGACY_COMPAT_STRAP,
  // Outputs.
  output logic IRQ,
  output logic GATE_START
);
  import daqis_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl; // Mode enables and routing.
  logic [7:0] thresh; // Blocks needed per FIFO event.
  logic [ST_W-1:0] stat; // Sticky event bits.
  logic [ST_W-1:0] mask; // Interrupt mask.
  logic legacy; // Sampled legacy strap.
  logic [8:0] sample_cnt; // Samples within the current block.
  logic [7:0] blk_cnt; // Blocks since the last FIFO event.
  logic gate_start; // Registered gating start pulse.
  logic aw_held; // Write address captured.
  logic [ADDR_W-1:0] aw_addr; // Captured write address.
  logic w_held; // Write data captured.
  logic [31:0] w_data; // Captured write data.
  logic [3:0] w_strb; // Captured byte strobes.
  logic bvalid; // Write response pending.
  logic [1:0] bresp; // Write response code.
  logic rvalid; // Read response pending.
  logic [31:0] rdata; // Read data.
  logic [1:0] rresp; // Read response code.

  // ----------------------------------------------------------------
  // Deglitch filter for digital input zero
  // ----------------------------------------------------------------
  daqis_dgl_if dg ();
  assign dg.raw = DIGITAL_INPUT_ZERO;

  daqis_deglitch u_dgl (
    .clk(CLK),
    .rst(RST),
    .dg(dg)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic analog_irq_enable, fifo_irq_enable, dma, fifo_mode_select, route_n, pacer_gate, classic;
  assign analog_irq_enable = ctrl[CB_ANALOG_IRQ];
  assign fifo_irq_enable = ctrl[CB_FIFO_IRQ];
  assign dma = ctrl[CB_DMA];
  assign fifo_mode_select = ctrl[CB_FIFO_MODE];
  assign route_n = ctrl[CB_ROUTE];
  assign pacer_gate = ctrl[CB_GATE];
  assign classic = !route_n;

  // Both FIFO enables without DMA select the input edge modes.
  logic din_mode;
  assign din_mode = classic && fifo_irq_enable && !dma && fifo_mode_select;

  // Interrupt source selection, first match wins.
  daqis_src_t irq_src;
  assign irq_src = !classic ? SRC_NONE :
                   (analog_irq_enable && dma) ? SRC_TC :
                   (analog_irq_enable && !dma && !fifo_mode_select) ? SRC_CONV :
                   (analog_irq_enable && !fifo_irq_enable && !dma && fifo_mode_select) ?
                     ((legacy && BURST_ACTIVE) ? SRC_BURST : SRC_CONV) :
                   (fifo_irq_enable && !dma && fifo_mode_select) ? SRC_BLOCK :
                   SRC_NONE;

  // Input edge raises the request only with both enables set.
  logic irq_din;
  assign irq_din = din_mode && analog_irq_enable;

  // ----------------------------------------------------------------
  // Sample block counting
  // ----------------------------------------------------------------
  logic block_tick, block_evt;
  logic [7:0] thresh_eff, blk_next;
  assign block_tick = SAMPLE_QUEUED && sample_cnt == SMP_LAST;
  assign thresh_eff = (thresh == 8'h00) ? BLK_STEP : thresh;
  assign blk_next = blk_cnt + BLK_STEP;
  assign block_evt = block_tick && blk_next >= thresh_eff;

  // Counts samples into blocks and blocks toward the threshold.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sample_cnt <= 9'h000;
      blk_cnt <= 8'h00;
    end
    else
    begin
      if (SAMPLE_QUEUED)
      begin
        sample_cnt <= sample_cnt + SMP_STEP;
      end
      if (block_tick)
      begin
        blk_cnt <= block_evt ? 8'h00 : blk_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event sets
  // ----------------------------------------------------------------
  logic src_hit, set_irq, set_evt, set_fblk, set_gate, fblk_on;
  assign src_hit = (irq_src == SRC_CONV && CONV_DONE) ||
                   (irq_src == SRC_BURST && BURST_DONE) ||
                   (irq_src == SRC_TC && DMA_TC) ||
                   (irq_src == SRC_BLOCK && block_evt);
  assign set_irq = src_hit || (irq_din && dg.rise);
  // Poll flag: TC with DMA, else conversion or input edge in FIFO mode.
  assign set_evt = classic && !analog_irq_enable && (dma ? DMA_TC :
                   (fifo_mode_select && (fifo_irq_enable ? dg.rise : CONV_DONE)));
  assign fblk_on = fifo_mode_select && ((!analog_irq_enable && dma) ||
                   (!fifo_irq_enable && !dma));
  assign set_fblk = classic && fblk_on && block_evt;
  assign set_gate = pacer_gate && dg.rise;

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic do_wr, wr_lo, wr_ctrl, wr_blks, wr_clr, wr_stat, wr_mask, wr_hit;
  assign do_wr = aw_held && w_held && !bvalid;
  assign wr_lo = do_wr && w_strb[0];
  assign wr_ctrl = wr_lo && aw_addr == OFF_CTRL;
  assign wr_blks = wr_lo && aw_addr == OFF_BLKS;
  assign wr_clr = do_wr && aw_addr == OFF_CLR;
  assign wr_stat = wr_lo && aw_addr == OFF_STAT;
  assign wr_mask = wr_lo && aw_addr == OFF_MASK;
  assign wr_hit = aw_addr == OFF_CTRL || aw_addr == OFF_BLKS ||
                  aw_addr == OFF_CLR || aw_addr == OFF_STAT ||
                  aw_addr == OFF_MASK || aw_addr == OFF_CNT;

  // Clear requests: one-to-clear on status, request bit on clear write.
  logic [ST_W-1:0] clr_bits, set_bits, next_stat;
  assign clr_bits = (wr_stat ? w_data[ST_W-1:0] : '0) |
                    (wr_clr ? {2'b00, din_mode, 1'b1} : '0);
  assign set_bits = {set_gate, set_fblk, set_evt, set_irq};
  assign next_stat = (stat & ~clr_bits) | set_bits;

  // ----------------------------------------------------------------
  // Configuration and status registers
  // ----------------------------------------------------------------
  // Holds software settings; status bits are sticky, sets beat clears.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl <= CTRL_RST;
      thresh <= BLKS_RST;
      mask <= MASK_RST;
      stat <= '0;
      legacy <= 1'b0;
      gate_start <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl <= w_data[CTRL_W-1:0];
      end
      if (wr_blks)
      begin
        thresh <= w_data[7:0];
      end
      if (wr_mask)
      begin
        mask <= w_data[ST_W-1:0];
      end
      stat <= next_stat;
      legacy <= LEGACY_COMPAT_STRAP;
      gate_start <= set_gate;
    end
  end

  assign IRQ = |(stat & mask);
  assign GATE_START = gate_start;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY = !aw_held && !bvalid;
  assign S_AXI_WREADY = !w_held && !bvalid;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;

  // Captures address and data in either order, then answers once.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_wr)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && S_AXI_BREADY)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic rd_hit;

  // Selects the word at the requested offset.
  always_comb
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (S_AXI_ARADDR == OFF_CTRL)
      rd_mux[CTRL_W-1:0] = ctrl;
    else if (S_AXI_ARADDR == OFF_BLKS)
      rd_mux[7:0] = thresh;
    else if (S_AXI_ARADDR == OFF_CLR)
      rd_mux = 32'h00000000;
    else if (S_AXI_ARADDR == OFF_STAT)
      rd_mux[ST_W-1:0] = stat;
    else if (S_AXI_ARADDR == OFF_MASK)
      rd_mux[ST_W-1:0] = mask;
    else if (S_AXI_ARADDR == OFF_CNT)
      rd_mux[16:0] = {blk_cnt, sample_cnt};
    else
      rd_hit = 1'b0;
  end

  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RDATA = rdata;
  assign S_AXI_RRESP = rresp;

  // Registers read data one cycle after the address is taken.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID && !rvalid)
    begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && S_AXI_RREADY)
    begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_route_blocks_irq: assert property (route_n && !stat[ST_IRQ] |=> !stat[ST_IRQ])
    else $error("Request rose with routing bit set.");
  a_tc_poll_flag: assert property (classic && !analog_irq_enable && dma && DMA_TC
    |=> stat[ST_EVT])
    else $error("Terminal count did not set poll flag.");
  a_tc_poll_noirq: assert property (classic && !analog_irq_enable && dma && !stat[ST_IRQ]
    |=> !stat[ST_IRQ])
    else $error("Request raised in DMA poll mode.");
  a_conv_irq: assert property (classic && analog_irq_enable && !dma && !fifo_mode_select
    && CONV_DONE |=> stat[ST_IRQ] && IRQ == mask[ST_IRQ])
    else $error("Conversion did not raise request.");
  a_clear_write: assert property (wr_clr && !set_irq |=> !stat[ST_IRQ])
    else $error("Clear write left request set.");
  a_legacy_sample: assert property (classic && legacy && analog_irq_enable && !dma
    && !fifo_mode_select |-> irq_src == SRC_CONV)
    else $error("Legacy mode lost per-sample source.");
  a_tc_irq: assert property (classic && analog_irq_enable && dma && DMA_TC |=> stat[ST_IRQ])
    else $error("Terminal count did not raise request.");
  a_conv_poll: assert property (classic && !analog_irq_enable && !fifo_irq_enable && !dma
    && fifo_mode_select && CONV_DONE |=> stat[ST_EVT] && !stat[ST_IRQ])
    else $error("Conversion poll flag wrong.");
  a_block_flag: assert property (classic && fblk_on && block_evt |=> stat[ST_FBLK])
    else $error("Block flag not set.");
  a_block_irq: assert property (classic && fifo_irq_enable && !dma && fifo_mode_select
    && block_evt |=> stat[ST_IRQ])
    else $error("Block did not raise request.");
  a_block_thresh: assert property (block_tick && blk_next < thresh_eff
    |-> !block_evt ##1 blk_cnt == $past(blk_next))
    else $error("Block threshold count wrong.");
  a_edge_poll: assert property (din_mode && !analog_irq_enable && dg.rise |=> stat[ST_EVT])
    else $error("Input edge did not set poll flag.");
  a_edge_clear: assert property (wr_clr && din_mode && !set_evt |=> !stat[ST_EVT])
    else $error("Clear write left edge flag set.");
  a_burst_src: assert property (classic && analog_irq_enable && !fifo_irq_enable && !dma
    && fifo_mode_select && legacy && BURST_ACTIVE |-> irq_src == SRC_BURST)
    else $error("Burst source not selected.");
  a_edge_irq: assert property (irq_din && dg.rise |=> stat[ST_IRQ])
    else $error("Input edge did not raise request.");
  a_gate_start: assert property (pacer_gate && dg.rise |=> GATE_START ##1 !GATE_START)
    else $error("Gate start pulse wrong.");
  a_sticky_hold: assert property (stat[ST_EVT] && !clr_bits[ST_EVT] |=> stat[ST_EVT])
    else $error("Poll flag dropped without clear.");

  c_conv_irq: cover property (irq_src == SRC_CONV && CONV_DONE ##1 IRQ);
  c_block_evt: cover property (block_evt && thresh_eff > BLK_STEP);
  c_edge_irq: cover property (irq_din && dg.rise ##1 IRQ);
  c_clear: cover property (stat[ST_IRQ] ##1 wr_clr ##1 !stat[ST_IRQ]);

endmodule // daqis_top

`default_nettype wire

// ===== verif/daqis_evt_model.sv
// Model of the acquisition front end that feeds the selector its events.
// Assumes the bench clock; every event line but burst_active rests low between events.
`timescale 1ns/10ps
`default_nettype none

module daqis_evt_model (
  // Clock.
  input wire logic clk,
  // Events toward the selector.
  output logic conv_done,
  output logic burst_done,
  output logic burst_active,
  output logic dma_tc,
  output logic sample_queued,
  output logic digital_input_zero
);
  // All lines start idle.
  initial
  begin
    conv_done = 1'b0;
    burst_done = 1'b0;
    burst_active = 1'b0;
    dma_tc = 1'b0;
    sample_queued = 1'b0;
    digital_input_zero = 1'b0;
  end

  // Fires one event: 0 conversion, 1 burst, 2 count, 3 input rise, 4 short glitch.
  task automatic fire(input int ev);
    int hold;
    hold = (ev == 4) ? 3 : 10;
    @(posedge clk);
    case (ev)
      0: conv_done <= 1'b1;
      1: burst_done <= 1'b1;
      2: dma_tc <= 1'b1;
      default: digital_input_zero <= 1'b1;
    endcase
    @(posedge clk);
    conv_done <= 1'b0;
    burst_done <= 1'b0;
    dma_tc <= 1'b0;
    if (ev > 2)
    begin
      // The input falls back low so that the next rise is a fresh one.
      repeat (hold - 1) @(posedge clk);
      digital_input_zero <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask

  // Holds the sample strobe for n edges, one sample per cycle.
  task automatic samples(input int n);
    @(posedge clk);
    sample_queued <= 1'b1;
    repeat (n) @(posedge clk);
    sample_queued <= 1'b0;
  endtask
endmodule // daqis_evt_model

`default_nettype wire

// ===== verif/daq_interrupt_source_select_tb.sv
// Self-checking bench for the interrupt source selector.
// Assumes the event model file and the design package are compiled first.
`timescale 1ns/10ps
`default_nettype none

module daq_interrupt_source_select_tb
  import daqis_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, irq, gate;
  logic [1:0] bresp, rresp, bx;
  logic [31:0] rdata;
  logic conv, bdone, bact, tc, sq, din;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] rx;
  logic [31:0] seed = 32'h3F58;
  logic [3:0] cur_mask = 4'h1;
  int fail_count = 0;
  int comparisons = 0;
  int gcount = 0;

  // ----------------------------------------------------------------
  // Clock, design and event source
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;

  daqis_top uut (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CONV_DONE(conv), .BURST_DONE(bdone),
    .BURST_ACTIVE(bact), .DMA_TC(tc), .SAMPLE_QUEUED(sq), .DIGITAL_INPUT_ZERO(din),
    .LEGACY_COMPAT_STRAP(strap), .IRQ(irq), .GATE_START(gate));

  daqis_evt_model m (.clk(clk), .conv_done(conv), .burst_done(bdone),
    .burst_active(bact), .dma_tc(tc), .sample_queued(sq), .digital_input_zero(din));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Compares one value and counts it.
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic give_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One register write; the expected response is noted for the monitor.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awrdy)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask

  // One register read; the expected word is noted for the monitor.
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arrdy)
        arv <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
  endtask

  // Monitor: takes the oldest note whenever a response is handed over.
  always @(posedge clk)
  begin
    if (rvalid && rready)
    begin
      rx = rq.pop_front();
      chk("rdata", rx[31:0], rdata);
      chk("rresp", {30'h0, rx[33:32]}, {30'h0, rresp});
    end
    if (bvalid && bready)
    begin
      bx = bq.pop_front();
      chk("bresp", {30'h0, bx}, {30'h0, bresp});
    end
    if (gate)
      gcount++;
  end

  // One mode: fire an event, check status and request, then clear both ways.
  task automatic row(input logic [5:0] c, input int ev, input logic leg, input logic [3:0] e);
    logic [3:0] k;
    strap <= leg;
    m.burst_active <= leg;
    wr(OFF_CTRL, {26'h0, c}, RESP_OKAY);
    m.fire(ev);
    repeat (4) @(posedge clk);
    rd(OFF_STAT, {28'h0, e}, RESP_OKAY);
    chk("irq", {31'h0, |(e & cur_mask)}, {31'h0, irq});
    // The clear write drops the event flag too only in the input edge modes.
    k = (c[1] && !c[2] && c[3] && !c[4]) ? 4'h3 : 4'h1;
    wr(OFF_CLR, 32'h0, RESP_OKAY);
    rd(OFF_STAT, {28'h0, e & ~k}, RESP_OKAY);
    chk("irq", {31'h0, |(e & ~k & cur_mask)}, {31'h0, irq});
    wr(OFF_STAT, 32'hF, RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  // Block counting from a fresh reset: nothing one sample early, event on the last.
  task automatic blk(input logic [5:0] c, input logic [7:0] b, input int n, input logic [3:0] e);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cur_mask = 4'h1;
    wr(OFF_BLKS, {24'h0, b}, RESP_OKAY);
    wr(OFF_CTRL, {26'h0, c}, RESP_OKAY);
    m.samples(n - 1);
    repeat (3) @(posedge clk);
    rd(OFF_STAT, 32'h0, RESP_OKAY);
    rd(OFF_CNT, n - 1, RESP_OKAY);
    m.samples(1);
    repeat (3) @(posedge clk);
    rd(OFF_STAT, {28'h0, e}, RESP_OKAY);
    chk("irq", {31'h0, e[0]}, {31'h0, irq});
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_BLKS, 32'h1, RESP_OKAY);
    rd(OFF_STAT, 32'h0, RESP_OKAY);
    rd(OFF_MASK, 32'h1, RESP_OKAY);
    rd(OFF_CLR, 32'h0, RESP_OKAY);
    wr(8'h40, 32'h1, RESP_SLVERR);
    repeat (4)
    begin
      seed = xs(seed);
      wr(OFF_BLKS, seed, RESP_OKAY);
      rd(OFF_BLKS, {24'h0, seed[7:0]}, RESP_OKAY);
      wr(OFF_MASK, seed, RESP_OKAY);
      rd(OFF_MASK, {28'h0, seed[3:0]}, RESP_OKAY);
    end
    wr(OFF_MASK, 32'h1, RESP_OKAY);
    row(6'h01, 0, 1'b0, 4'h1);
    row(6'h01, 0, 1'b1, 4'h1);
    row(6'h04, 2, 1'b0, 4'h2);
    row(6'h05, 2, 1'b0, 4'h1);
    row(6'h0D, 2, 1'b0, 4'h1);
    row(6'h08, 0, 1'b0, 4'h2);
    row(6'h09, 1, 1'b1, 4'h1);
    row(6'h09, 0, 1'b1, 4'h0);
    row(6'h09, 0, 1'b0, 4'h1);
    row(6'h0A, 3, 1'b0, 4'h2);
    row(6'h0A, 4, 1'b0, 4'h0);
    row(6'h0B, 3, 1'b0, 4'h1);
    row(6'h2A, 3, 1'b0, 4'hA);
    row(6'h11, 0, 1'b0, 4'h0);
    row(6'h1B, 3, 1'b0, 4'h0);
    chk("gate", 32'h1, gcount);
    wr(OFF_MASK, 32'h2, RESP_OKAY);
    cur_mask = 4'h2;
    row(6'h04, 2, 1'b0, 4'h2);
    blk(6'h0A, 8'h02, 1024, 4'h1);
    blk(6'h08, 8'h00, 512, 4'h4);
    blk(6'h0C, 8'h01, 512, 4'h4);
    blk(6'h0B, 8'h01, 512, 4'h1);
    give_verdict();
  end

  // Cuts a hang short well beyond the few thousand cycles the tests need.
  initial
  begin
    #(25 * 30000);
    fail_count++;
    give_verdict();
  end
endmodule // daq_interrupt_source_select_tb

`default_nettype wire
